// ==== dadc_regs.vh ====
/*
 * Constants for the dual converter output port: pipeline depth,
 * code width and the encodings of the four-level mode input.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DADC_REGS_VH
`define DADC_REGS_VH

// Code and latency
`define DADC_CODE_W 10
`define DADC_LATENCY 5

// Mode input levels as a two-bit code
`define DADC_MODE_GND 2'h0
`define DADC_MODE_THIRD 2'h1
`define DADC_MODE_TWO_THIRDS 2'h2
`define DADC_MODE_FULL 2'h3

`endif

// ==== dadc_channel.v ====
/*
 * One converter channel: samples on its own clock edge, delays the
 * code and range flag through a fixed pipeline, formats the word.
 * Assumes the channel clock is a level sampled on CLK_I domain.
 */
`include "dadc_regs.vh"
`default_nettype none

module dadc_channel #(
  parameter CODE_W = `DADC_CODE_W,
  parameter LATENCY = `DADC_LATENCY
) (
  input wire clk_i,
  input wire rst_i,
  input wire sample_edge_i,
  input wire powered_i,
  input wire twos_i,
  input wire [CODE_W-1:0] code_i,
  input wire over_i,
  output reg [CODE_W-1:0] word_o,
  output reg flag_o
);

  // ********************************************
  // Pipeline, advanced once per sample edge while the channel is powered
  // ********************************************
  reg [CODE_W-1:0] code_pipe [0:LATENCY-1];
  reg [LATENCY-1:0] flag_pipe;
  integer k;

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (k = 0; k < LATENCY; k = k + 1) begin
        code_pipe[k] <= {CODE_W{1'b0}};
      end
      flag_pipe <= {LATENCY{1'b0}};
      word_o <= {CODE_W{1'b0}};
      flag_o <= 1'b0;
    end else if (sample_edge_i && powered_i) begin
      code_pipe[0] <= code_i;
      flag_pipe[0] <= over_i;
      for (k = 1; k < LATENCY; k = k + 1) begin
        code_pipe[k] <= code_pipe[k-1];
        flag_pipe[k] <= flag_pipe[k-1];
      end
      // Word leaves on the fifth edge after its own sample
      word_o <= twos_i ? {~code_pipe[LATENCY-1][CODE_W-1],
                          code_pipe[LATENCY-1][CODE_W-2:0]}
                       : code_pipe[LATENCY-1];
      flag_o <= flag_pipe[LATENCY-1];
    end
  end

endmodule // dadc_channel
`default_nettype wire

// ==== dadc_port.v ====
/*
 * Digital output port of a dual 10-bit sampling converter: sample
 * pipelines, output format, bus swap and per-channel power states.
 * Assumes converted codes arrive on CLK_I; pin levels are async.
 */
//
// Overview of operation
// - Each channel samples on rising edge of its own sample clock.
// - Swap high: A on bus A, B on bus B; low: buses exchanged.
// - Power-down low converts; enable low drives outputs, high floats them.
// - Power-down high: nap or sleep by enable; outputs float.
// - Shared mode input picks format and stabilizer for both channels.
// - Overflow flag high for any out-of-range sample.
// - Ten-bit word, highest line is most significant bit.
// - Result appears five sample clocks after its sample.
`include "dadc_regs.vh"
`default_nettype none

module dadc_port #(
  parameter CODE_W = `DADC_CODE_W,
  parameter LATENCY = `DADC_LATENCY
) (
  input wire CLK_I,
  input wire SYS_RST_I,
  input wire SAMPLE_CLOCK_FIRST_I,
  input wire SAMPLE_CLOCK_SECOND_I,
  input wire BUS_SWAP_SELECT_I,
  input wire POWER_DOWN_FIRST_I,
  input wire POWER_DOWN_SECOND_I,
  input wire OUTPUT_ENABLE_N_FIRST_I,
  input wire OUTPUT_ENABLE_N_SECOND_I,
  input wire [1:0] MODE_LEVEL_I,
  input wire [CODE_W-1:0] CODE_FIRST_I,
  input wire OVER_FIRST_I,
  input wire [CODE_W-1:0] CODE_SECOND_I,
  input wire OVER_SECOND_I,
  output reg [CODE_W-1:0] SAMPLE_BUS_FIRST_O,
  output reg RANGE_FLAG_FIRST_O,
  output reg BUS_FIRST_OE_N_O,
  output reg [CODE_W-1:0] SAMPLE_BUS_SECOND_O,
  output reg RANGE_FLAG_SECOND_O,
  output reg BUS_SECOND_OE_N_O,
  output reg STABILIZER_ON_O,
  output reg NAP_FIRST_O,
  output reg SLEEP_FIRST_O,
  output reg NAP_SECOND_O,
  output reg SLEEP_SECOND_O
);

  // ********************************************
  // Pin synchronisers, two flops each
  // ********************************************
  reg [8:0] meta;
  reg [8:0] sync;
  reg [1:0] clk_prev;

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      meta <= 9'h000;
      sync <= 9'h000;
      clk_prev <= 2'h0;
    end else begin
      meta <= {MODE_LEVEL_I, OUTPUT_ENABLE_N_SECOND_I, OUTPUT_ENABLE_N_FIRST_I,
               POWER_DOWN_SECOND_I, POWER_DOWN_FIRST_I, BUS_SWAP_SELECT_I,
               SAMPLE_CLOCK_SECOND_I, SAMPLE_CLOCK_FIRST_I};
      sync <= meta;
      clk_prev <= sync[1:0];
    end
  end

  // Edges come from the second flop and its delayed copy in clk_prev, never from the first
  wire edge_first = sync[0] & ~clk_prev[0];
  wire edge_second = sync[1] & ~clk_prev[1];
  wire swap_n = sync[2];
  wire pd_first = sync[3];
  wire pd_second = sync[4];
  wire oen_first = sync[5];
  wire oen_second = sync[6];
  wire [1:0] mode = sync[8:7];

  // ********************************************
  // Mode decode, shared by both channels
  // ********************************************
  reg twos;
  reg next_stab;

  // A new level reaches each channel at its next sample edge
  always @* begin
    case (mode)
      `DADC_MODE_GND: begin
        twos = 1'b0;
        next_stab = 1'b0;
      end
      `DADC_MODE_THIRD: begin
        twos = 1'b0;
        next_stab = 1'b1;
      end
      `DADC_MODE_TWO_THIRDS: begin
        twos = 1'b1;
        next_stab = 1'b1;
      end
      default: begin
        twos = 1'b1;
        next_stab = 1'b0;
      end
    endcase
  end

  // ********************************************
  // Channels
  // ********************************************
  wire [CODE_W-1:0] word_first;
  wire [CODE_W-1:0] word_second;
  wire flag_first;
  wire flag_second;

  // Shared format decode, separate pipelines per channel
  dadc_channel #(.CODE_W(CODE_W), .LATENCY(LATENCY)) u_first (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .sample_edge_i(edge_first),
    .powered_i(~pd_first),
    .twos_i(twos),
    .code_i(CODE_FIRST_I),
    .over_i(OVER_FIRST_I),
    .word_o(word_first),
    .flag_o(flag_first)
  );

  dadc_channel #(.CODE_W(CODE_W), .LATENCY(LATENCY)) u_second (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .sample_edge_i(edge_second),
    .powered_i(~pd_second),
    .twos_i(twos),
    .code_i(CODE_SECOND_I),
    .over_i(OVER_SECOND_I),
    .word_o(word_second),
    .flag_o(flag_second)
  );

  // ********************************************
  // Output routing and drive enables
  // ********************************************
  // Drive follows the channel, so enables swap along with the data
  wire drive_first = ~pd_first & ~oen_first;
  wire drive_second = ~pd_second & ~oen_second;

  reg [CODE_W-1:0] next_bus_first;
  reg [CODE_W-1:0] next_bus_second;
  reg next_flag_first;
  reg next_flag_second;
  reg next_oe_n_first;
  reg next_oe_n_second;

  always @* begin
    if (swap_n) begin
      next_bus_first = word_first;
      next_flag_first = flag_first;
      next_oe_n_first = ~drive_first;
      next_bus_second = word_second;
      next_flag_second = flag_second;
      next_oe_n_second = ~drive_second;
    end else begin
      next_bus_first = word_second;
      next_flag_first = flag_second;
      next_oe_n_first = ~drive_second;
      next_bus_second = word_first;
      next_flag_second = flag_first;
      next_oe_n_second = ~drive_first;
    end
  end

  // Floated in reset; zeroed synchronisers then enable drive until the pins are known
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      SAMPLE_BUS_FIRST_O <= {CODE_W{1'b0}};
      SAMPLE_BUS_SECOND_O <= {CODE_W{1'b0}};
      RANGE_FLAG_FIRST_O <= 1'b0;
      RANGE_FLAG_SECOND_O <= 1'b0;
      BUS_FIRST_OE_N_O <= 1'b1;
      BUS_SECOND_OE_N_O <= 1'b1;
    end else begin
      SAMPLE_BUS_FIRST_O <= next_bus_first;
      SAMPLE_BUS_SECOND_O <= next_bus_second;
      RANGE_FLAG_FIRST_O <= next_flag_first;
      RANGE_FLAG_SECOND_O <= next_flag_second;
      BUS_FIRST_OE_N_O <= next_oe_n_first;
      BUS_SECOND_OE_N_O <= next_oe_n_second;
    end
  end

  // ********************************************
  // Power states and stabilizer
  // ********************************************
  // Status levels lag the pins by the same three cycles as the enables
  reg next_nap_first;
  reg next_sleep_first;
  reg next_nap_second;
  reg next_sleep_second;

  always @* begin
    next_nap_first = pd_first & ~oen_first;
    next_sleep_first = pd_first & oen_first;
    next_nap_second = pd_second & ~oen_second;
    next_sleep_second = pd_second & oen_second;
  end

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      STABILIZER_ON_O <= 1'b0;
      NAP_FIRST_O <= 1'b0;
      SLEEP_FIRST_O <= 1'b0;
      NAP_SECOND_O <= 1'b0;
      SLEEP_SECOND_O <= 1'b0;
    end else begin
      STABILIZER_ON_O <= next_stab;
      NAP_FIRST_O <= next_nap_first;
      SLEEP_FIRST_O <= next_sleep_first;
      NAP_SECOND_O <= next_nap_second;
      SLEEP_SECOND_O <= next_sleep_second;
    end
  end

endmodule // dadc_port
`default_nettype wire

// ==== dadc_capture_model.sv ====
/* Capture logic on the far side of one output bus.
   Assumes the bus enable is active low. */
`default_nettype none
module dadc_capture_model (
  input wire logic clk_i,
  input wire logic [9:0] bus_i,
  input wire logic flag_i,
  input wire logic oe_n_i,
  output logic [10:0] seen_o
);
  logic [10:0] held;
  always @(posedge clk_i) if (!oe_n_i) held <= {flag_i, bus_i};
  // Floated bus reads as inverse of its last level
  assign seen_o = oe_n_i ? ~held : {flag_i, bus_i};
endmodule // dadc_capture_model
`default_nettype wire

// ==== dadc_port_checker.sv ====
/* Assertions on the port levels and output timing.
   Assumes binding to the top module, pins lagging three cycles. */
`default_nettype none
module dadc_port_checker #(parameter int CODE_W = 10) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SAMPLE_CLOCK_FIRST_I,
  input wire logic SAMPLE_CLOCK_SECOND_I,
  input wire logic BUS_SWAP_SELECT_I,
  input wire logic POWER_DOWN_FIRST_I,
  input wire logic POWER_DOWN_SECOND_I,
  input wire logic OUTPUT_ENABLE_N_FIRST_I,
  input wire logic OUTPUT_ENABLE_N_SECOND_I,
  input wire logic [1:0] MODE_LEVEL_I,
  input wire logic [CODE_W-1:0] SAMPLE_BUS_FIRST_O,
  input wire logic [CODE_W-1:0] SAMPLE_BUS_SECOND_O,
  input wire logic BUS_FIRST_OE_N_O,
  input wire logic BUS_SECOND_OE_N_O,
  input wire logic STABILIZER_ON_O,
  input wire logic NAP_FIRST_O,
  input wire logic SLEEP_FIRST_O,
  input wire logic NAP_SECOND_O,
  input wire logic SLEEP_SECOND_O
);
  logic [6:0] d1, d2, d3;
  logic [3:0] since_rst, since_edge, since_cfg;
  function automatic logic [3:0] sat(input logic [3:0] v);
    return v + {3'h0, v != 4'hf};
  endfunction
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  always_ff @(posedge CLK_I) begin
    {d3, d2, d1} <= {d2, d1, MODE_LEVEL_I, BUS_SWAP_SELECT_I, POWER_DOWN_FIRST_I,
      POWER_DOWN_SECOND_I, OUTPUT_ENABLE_N_FIRST_I, OUTPUT_ENABLE_N_SECOND_I};
    since_rst <= SYS_RST_I ? 4'h0 : sat(since_rst);
    since_edge <= (SYS_RST_I || $rose(SAMPLE_CLOCK_FIRST_I) || $rose(SAMPLE_CLOCK_SECOND_I))
      ? 4'h0 : sat(since_edge);
    since_cfg <= (SYS_RST_I || d1[6:4] != {MODE_LEVEL_I, BUS_SWAP_SELECT_I}) ? 4'h0
      : sat(since_cfg);
  end
  // Synchronisers refill after reset before levels can be judged
  wire ok = since_rst > 4'h3;
  first_bus_float_a: assert property (ok |-> BUS_FIRST_OE_N_O ==
    (d3[4] ? d3[3] | d3[1] : d3[2] | d3[0])) else $error("bus A enable wrong");
  second_bus_float_a: assert property (ok |-> BUS_SECOND_OE_N_O ==
    (d3[4] ? d3[2] | d3[0] : d3[3] | d3[1])) else $error("bus B enable wrong");
  nap_first_a: assert property (ok |-> NAP_FIRST_O == (d3[3] & !d3[1]))
    else $error("nap A wrong");
  sleep_first_a: assert property (ok |-> SLEEP_FIRST_O == (d3[3] & d3[1]))
    else $error("sleep A wrong");
  doze_second_a: assert property (ok |-> {NAP_SECOND_O, SLEEP_SECOND_O} ==
    {d3[2] & !d3[0], d3[2] & d3[0]}) else $error("power state B wrong");
  stabilizer_mode_a: assert property (ok |-> STABILIZER_ON_O == (d3[6] ^ d3[5]))
    else $error("stabilizer wrong");
  edge_timing_first_a: assert property (since_cfg > 4'h8 &&
    $changed(SAMPLE_BUS_FIRST_O) |-> since_edge inside {[4'h2:4'h6]}) else $error("bus A moved");
  edge_timing_second_a: assert property (since_cfg > 4'h8 &&
    $changed(SAMPLE_BUS_SECOND_O) |-> since_edge inside {[4'h2:4'h6]}) else $error("bus B moved");
endmodule // dadc_port_checker
`default_nettype wire

// ==== dadc_port_bench.sv ====
/* Self-checking bench for the dual converter output port.
   Assumes the capture model and checker are compiled first. */
`default_nettype none
module dadc_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sc1 = 0, sc2 = 0, swap = 1, pd1 = 0, pd2 = 0, oe1 = 0, oe2 = 0;
  logic ov1 = 0, ov2 = 0, f1, f2, en1, en2, stab, nap1, slp1, nap2, slp2;
  logic [1:0] mode = 2'h0;
  logic [9:0] c1 = 10'h0, c2 = 10'h0, b1, b2;
  logic [10:0] s1, s2;
  int n_mismatch = 0, n_tests = 0;
  always #4 clk = ~clk;
  dadc_port DUT (.CLK_I(clk), .SYS_RST_I(rst), .SAMPLE_CLOCK_FIRST_I(sc1),
    .SAMPLE_CLOCK_SECOND_I(sc2), .BUS_SWAP_SELECT_I(swap), .POWER_DOWN_FIRST_I(pd1),
    .POWER_DOWN_SECOND_I(pd2), .OUTPUT_ENABLE_N_FIRST_I(oe1), .OUTPUT_ENABLE_N_SECOND_I(oe2),
    .MODE_LEVEL_I(mode), .CODE_FIRST_I(c1), .OVER_FIRST_I(ov1), .CODE_SECOND_I(c2),
    .OVER_SECOND_I(ov2), .SAMPLE_BUS_FIRST_O(b1), .RANGE_FLAG_FIRST_O(f1),
    .BUS_FIRST_OE_N_O(en1), .SAMPLE_BUS_SECOND_O(b2), .RANGE_FLAG_SECOND_O(f2),
    .BUS_SECOND_OE_N_O(en2), .STABILIZER_ON_O(stab), .NAP_FIRST_O(nap1),
    .SLEEP_FIRST_O(slp1), .NAP_SECOND_O(nap2), .SLEEP_SECOND_O(slp2));
  dadc_capture_model cap1 (.clk_i(clk), .bus_i(b1), .flag_i(f1), .oe_n_i(en1), .seen_o(s1));
  dadc_capture_model cap2 (.clk_i(clk), .bus_i(b2), .flag_i(f2), .oe_n_i(en2), .seen_o(s2));
  function automatic logic [9:0] fmt(input logic [9:0] c, input logic [1:0] m);
    return m[1] ? c ^ 10'h200 : c;
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [1:0] which, input int n);
    repeat (n) begin
      sc1 <= which[0];
      sc2 <= which[1];
      repeat (4) @(posedge clk);
      sc1 <= 1'b0;
      sc2 <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    c1 <= 10'h2a5;
    ov1 <= 1'b1;
    c2 <= 10'h01c;
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      pulse(2'h3, 7);
      check(s1, {1'b1, fmt(10'h2a5, m[1:0])});
      check(s2, {1'b0, fmt(10'h01c, m[1:0])});
      check({10'h0, stab}, {10'h0, m[0] ^ m[1]});
    end
    swap <= 1'b0;
    repeat (5) @(posedge clk);
    check(s1, {1'b0, fmt(10'h01c, 2'h3)});
    check(s2, {1'b1, fmt(10'h2a5, 2'h3)});
    swap <= 1'b1;
    c1 <= 10'h155;
    ov1 <= 1'b0;
    pulse(2'h1, 1);
    c1 <= 10'h0f0;
    pulse(2'h1, 4);
    check(s1, {1'b1, fmt(10'h2a5, 2'h3)});
    pulse(2'h1, 1);
    check(s1, {1'b0, fmt(10'h155, 2'h3)});
    c2 <= 10'h3ff;
    pulse(2'h2, 6);
    check(s2, {1'b0, fmt(10'h3ff, 2'h3)});
    check(s1, {1'b0, fmt(10'h155, 2'h3)});
    for (int r = 0; r < 2; r++) begin
      {sc1, sc2, swap} <= 3'h7;
      repeat (5) @(posedge clk);
      check(s1, {1'b0, fmt(10'h0f0, 2'h3)});
      {sc1, sc2, swap} <= 3'h0;
      repeat (5) @(posedge clk);
      check(s1, {1'b0, fmt(10'h3ff, 2'h3)});
    end
    swap <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      {pd1, oe1} <= p[1:0];
      {pd2, oe2} <= p[1:0];
      repeat (5) @(posedge clk);
      check({8'h0, en1, nap1, slp1}, {8'h0, p[1] | p[0], p == 2, p == 3});
      check({8'h0, en2, nap2, slp2}, {8'h0, p[1] | p[0], p == 2, p == 3});
    end
    wrap_up;
  end
endmodule // dadc_port_bench
bind dadc_port dadc_port_checker #(.CODE_W(CODE_W)) u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .SAMPLE_CLOCK_FIRST_I(SAMPLE_CLOCK_FIRST_I), .SAMPLE_CLOCK_SECOND_I(SAMPLE_CLOCK_SECOND_I),
  .BUS_SWAP_SELECT_I(BUS_SWAP_SELECT_I), .POWER_DOWN_FIRST_I(POWER_DOWN_FIRST_I),
  .POWER_DOWN_SECOND_I(POWER_DOWN_SECOND_I),
  .OUTPUT_ENABLE_N_FIRST_I(OUTPUT_ENABLE_N_FIRST_I),
  .OUTPUT_ENABLE_N_SECOND_I(OUTPUT_ENABLE_N_SECOND_I), .MODE_LEVEL_I(MODE_LEVEL_I),
  .SAMPLE_BUS_FIRST_O(SAMPLE_BUS_FIRST_O), .SAMPLE_BUS_SECOND_O(SAMPLE_BUS_SECOND_O),
  .BUS_FIRST_OE_N_O(BUS_FIRST_OE_N_O), .BUS_SECOND_OE_N_O(BUS_SECOND_OE_N_O),
  .STABILIZER_ON_O(STABILIZER_ON_O), .NAP_FIRST_O(NAP_FIRST_O), .SLEEP_FIRST_O(SLEEP_FIRST_O),
  .NAP_SECOND_O(NAP_SECOND_O), .SLEEP_SECOND_O(SLEEP_SECOND_O));
`default_nettype wire
